// ### design/pseq_pkg.sv
// Package with constants and carrier types of the program sequencer.
// Contract
// - Program memory holds 2K words; reset vector is the single word at address zero.
// - Reset cause flags: power-on 1/0, watchdog 0/0, external 1/1 (timeout/power-down).
// - Any reset restarts fetch at address zero and restores all registers to defaults.
// - Interrupt service saves the program counter to the stack buffer, jumps to vector.
// - Save copies accumulator and flags; restore reloads them, sparing timeout and power-down.
// - Save/restore buffer is one level deep; a second save overwrites the first.
// - Table read address is table high register bits 15:8, table low bits 7:0.
// - Table read puts low byte in accumulator, high byte in table data high.
// - Table low increment wraps to zero without carrying into table high.
// - Accumulator plus pc low byte gives new low byte; carry increments pc high.
// - Borrow from pc low minus accumulator leaves pc high unchanged.
// - Each program word is 16 bits, returned whole across two byte registers.
package pseq_pkg;
	localparam int          PC_W        = 11;
	localparam int          ROM_WORDS   = 2048;
	localparam logic [10:0] RESET_VEC   = 11'h000;
	localparam logic [10:0] IRQ_VEC     = 11'h008;
	localparam logic [7:0]  BYTE_RST    = 8'h00;
	localparam logic [7:0]  FLAG_RST    = 8'h00;
	localparam int          FLAG_TO_BIT = 2;
	localparam int          FLAG_PD_BIT = 3;
	localparam logic [7:0]  FLAG_KEEP   = 8'h0C;
	localparam int          STACK_DEPTH = 8;

	typedef enum logic [1:0] {PSEQ_RST_POWER, PSEQ_RST_WDOG, PSEQ_RST_EXT} pseq_cause_e;

	typedef enum logic [3:0]
	{
		PSEQ_OP_NONE,
		PSEQ_OP_STEP,
		PSEQ_OP_JUMP,
		PSEQ_OP_CALL,
		PSEQ_OP_RET,
		PSEQ_OP_IRQ,
		PSEQ_OP_ADDPCL,
		PSEQ_OP_SUBPCL,
		PSEQ_OP_SAVE,
		PSEQ_OP_RESTORE,
		PSEQ_OP_TABLE,
		PSEQ_OP_INC_TLO,
		PSEQ_OP_INC_THI
	} pseq_op_e;

	typedef struct packed
	{
		pseq_op_e    op;
		logic [10:0] target;
	} pseq_cmd_s;

	typedef struct packed
	{
		logic [7:0] accumulator;
		logic [7:0] program_flag_register;
	} pseq_ctx_s;
endpackage

// ### design/pseq_stack.sv
// Return address stack of the program sequencer.
`timescale 1ns/100ps
module pseq_stack
(
	input  wire logic        core_clk, // Core instruction clock.
	input  wire logic        srst,     // Synchronous reset, active high.
	input  wire logic        push,     // Push request.
	input  wire logic        pop,      // Pop request.
	input  wire logic [10:0] din,      // Address to save.
	output logic      [10:0] dout      // Top of stack.
);
	logic [10:0] mem [pseq_pkg::STACK_DEPTH];
	logic [2:0]  ptr;
	wire  [2:0]  top_idx = ptr - 3'h1;

	assign dout = mem[top_idx];

	// Overflow wraps and overwrites the oldest entry, as a fixed ring does.
	always_ff @(posedge core_clk)
	begin
		if (srst)
			ptr <= 3'h0;
		else if (push)
			ptr <= ptr + 3'h1;
		else if (pop)
			ptr <= top_idx;
	end

	genvar gi;
	generate
		for (gi = 0; gi < pseq_pkg::STACK_DEPTH; gi++)
		begin : g_ent
			always_ff @(posedge core_clk)
			begin
				if (srst)
					mem[gi] <= pseq_pkg::RESET_VEC;
				else if (push && ptr == 3'(gi))
					mem[gi] <= din;
			end
		end
	endgenerate
endmodule

// ### design/pseq_top.sv
// Program counter, vectors, save buffer and table read of the program sequencer.
`timescale 1ns/100ps
module pseq_top
(
	input  wire logic                  core_clk,      // Core instruction clock, 20 MHz.
	input  wire logic                  srst,          // Synchronous reset, active high.
	input  wire pseq_pkg::pseq_cause_e rst_cause,     // Cause of the present reset.
	input  wire pseq_pkg::pseq_cmd_s   cmd,           // Operation for this cycle.
	input  wire logic                  acc_wr,        // Write accumulator from acc_wdata.
	input  wire logic [7:0]            acc_wdata,     // Accumulator write data.
	input  wire logic                  flag_wr,       // Write flag register (not TO/PD).
	input  wire logic [7:0]            flag_wdata,    // Flag register write data.
	input  wire logic                  tlo_wr,        // Write table low address.
	input  wire logic                  thi_wr,        // Write table high address.
	input  wire logic [7:0]            taddr_wdata,   // Table address write data.
	input  wire logic [15:0]           rom_rdata,     // Program word at rom_addr.
	output logic      [10:0]           pc,            // Program counter, fetch address.
	output logic      [10:0]           rom_addr,      // Program memory address.
	output logic      [7:0]            pc_high_byte,  // Program counter high byte.
	output logic      [7:0]            pc_low_byte,   // Program counter low byte.
	output pseq_pkg::pseq_ctx_s        ctx,           // Accumulator and flag register.
	output logic      [7:0]            table_lo,      // Table low address.
	output logic      [7:0]            table_hi,      // Table high address.
	output logic      [7:0]            table_data_hi, // High byte of last table read.
	output logic                       table_done     // Pulse: table read finished.
);
	pseq_pkg::pseq_ctx_s save_buf;
	logic                tbl_pend;
	logic                was_rst;
	wire  [10:0]         stack_top;

	wire pseq_pkg::pseq_op_e op = cmd.op;
	wire is_irq  = op == pseq_pkg::PSEQ_OP_IRQ;
	wire is_call = op == pseq_pkg::PSEQ_OP_CALL;
	wire do_push = is_irq | is_call;
	wire do_pop  = op == pseq_pkg::PSEQ_OP_RET;

	// Low byte arithmetic: the carry bit is kept, the borrow bit is dropped.
	wire [8:0]  add_sum  = {1'b0, pc[7:0]} + {1'b0, ctx.accumulator};
	wire [7:0]  sub_diff = pc[7:0] - ctx.accumulator;
	wire [2:0]  add_hi   = pc[10:8] + {2'b00, add_sum[8]};
	wire [10:0] pc_inc   = pc + 11'h001;

	// Table address is 16 bits; only the low eleven reach the 2K-word array.
	wire [15:0] tbl_addr = {table_hi, table_lo};

	logic [10:0] next_pc;
	always_comb
	begin
		unique case (op)
			pseq_pkg::PSEQ_OP_STEP:   next_pc = pc_inc;
			pseq_pkg::PSEQ_OP_JUMP:   next_pc = cmd.target;
			pseq_pkg::PSEQ_OP_CALL:   next_pc = cmd.target;
			pseq_pkg::PSEQ_OP_RET:    next_pc = stack_top;
			pseq_pkg::PSEQ_OP_IRQ:    next_pc = pseq_pkg::IRQ_VEC;
			pseq_pkg::PSEQ_OP_ADDPCL: next_pc = {add_hi, add_sum[7:0]};
			pseq_pkg::PSEQ_OP_SUBPCL: next_pc = {pc[10:8], sub_diff};
			default:                  next_pc = pc;
		endcase
	end

	wire [10:0] next_rom_addr = (op == pseq_pkg::PSEQ_OP_TABLE) ? tbl_addr[10:0] : next_pc;

	pseq_stack u_stack
	(
		.core_clk (core_clk),
		.srst     (srst),
		.push     (do_push),
		.pop      (do_pop),
		.din      (is_irq ? pc : pc_inc),
		.dout     (stack_top)
	);

	logic [7:0] rst_flags;
	always_comb
	begin
		rst_flags = pseq_pkg::FLAG_RST;
		unique case (rst_cause)
			pseq_pkg::PSEQ_RST_POWER:
			begin
				rst_flags[pseq_pkg::FLAG_TO_BIT] = 1'b1;
				rst_flags[pseq_pkg::FLAG_PD_BIT] = 1'b0;
			end
			pseq_pkg::PSEQ_RST_WDOG:
			begin
				rst_flags[pseq_pkg::FLAG_TO_BIT] = 1'b0;
				rst_flags[pseq_pkg::FLAG_PD_BIT] = 1'b0;
			end
			pseq_pkg::PSEQ_RST_EXT:
			begin
				rst_flags[pseq_pkg::FLAG_TO_BIT] = 1'b1;
				rst_flags[pseq_pkg::FLAG_PD_BIT] = 1'b1;
			end
			default: rst_flags = pseq_pkg::FLAG_RST;
		endcase
	end

	wire [7:0] keep = pseq_pkg::FLAG_KEEP;
	wire [7:0] flag_merge_wr = (flag_wdata & ~keep) | (ctx.program_flag_register & keep);
	wire [7:0] flag_merge_rs = (save_buf.program_flag_register & ~keep)
		| (ctx.program_flag_register & keep);

	logic [7:0] next_acc;
	logic [7:0] next_flag;
	always_comb
	begin
		next_acc  = ctx.accumulator;
		next_flag = ctx.program_flag_register;
		if (op == pseq_pkg::PSEQ_OP_RESTORE)
		begin
			next_acc  = save_buf.accumulator;
			next_flag = flag_merge_rs;
		end
		else if (tbl_pend)
			next_acc = rom_rdata[7:0];
		else if (acc_wr)
			next_acc = acc_wdata;
		if (flag_wr && op != pseq_pkg::PSEQ_OP_RESTORE)
			next_flag = flag_merge_wr;
	end

	// Reset cause is latched at the first edge after reset, never by the reset itself.
	always_ff @(posedge core_clk)
	begin
		was_rst <= srst;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			pc       <= pseq_pkg::RESET_VEC;
			rom_addr <= pseq_pkg::RESET_VEC;
		end
		else
		begin
			pc       <= next_pc;
			rom_addr <= next_rom_addr;
		end
	end

	// The byte views of the counter have flops of their own so that they leave the block
	// registered; the price is a second copy of the counter.
	wire [7:0] next_pc_low  = next_pc[7:0];
	wire [7:0] next_pc_high = {5'h00, next_pc[10:8]};

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			pc_low_byte  <= pseq_pkg::RESET_VEC[7:0];
			pc_high_byte <= {5'h00, pseq_pkg::RESET_VEC[10:8]};
		end
		else
		begin
			pc_low_byte  <= next_pc_low;
			pc_high_byte <= next_pc_high;
		end
	end

	// The cause code enters on the first edge after release and overrides a flag write there.
	wire [7:0] next_flag_reg = was_rst ? rst_flags : next_flag;

	always_ff @(posedge core_clk)
	begin
		if (srst)
			ctx <= {pseq_pkg::BYTE_RST, pseq_pkg::FLAG_RST};
		else
			ctx <= {next_acc, next_flag_reg};
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			save_buf <= {pseq_pkg::BYTE_RST, pseq_pkg::FLAG_RST};
		else if (op == pseq_pkg::PSEQ_OP_SAVE)
			save_buf <= ctx;
	end

	// Software writes to the table address win over an increment in the same cycle.
	wire       is_table = op == pseq_pkg::PSEQ_OP_TABLE;
	wire       inc_tlo  = op == pseq_pkg::PSEQ_OP_INC_TLO;
	wire       inc_thi  = op == pseq_pkg::PSEQ_OP_INC_THI;
	wire [7:0] tlo_inc  = table_lo + 8'h01;
	wire [7:0] thi_inc  = table_hi + 8'h01;
	wire [7:0] next_table_lo = tlo_wr ? taddr_wdata : (inc_tlo ? tlo_inc : table_lo);
	wire [7:0] next_table_hi = thi_wr ? taddr_wdata : (inc_thi ? thi_inc : table_hi);
	wire [7:0] next_table_data_hi = tbl_pend ? rom_rdata[15:8] : table_data_hi;

	always_ff @(posedge core_clk)
	begin
		if (srst)
			table_lo <= pseq_pkg::BYTE_RST;
		else
			table_lo <= next_table_lo;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			table_hi <= pseq_pkg::BYTE_RST;
		else
			table_hi <= next_table_hi;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			table_data_hi <= pseq_pkg::BYTE_RST;
		else
			table_data_hi <= next_table_data_hi;
	end

	// The data arrives one cycle after the table op; done follows one cycle later again.
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			tbl_pend   <= 1'b0;
			table_done <= 1'b0;
		end
		else
		begin
			tbl_pend   <= is_table;
			table_done <= tbl_pend;
		end
	end

endmodule

// ### bench/pseq_top_asserts.sv
// Port assertions for the program sequencer.
`timescale 1ns/100ps
module pseq_checker
(
	input wire logic                core_clk,  // Clock.
	input wire logic                srst,      // Reset.
	input wire pseq_pkg::pseq_cmd_s cmd,       // Operation.
	input wire logic [10:0]         pc,        // Counter.
	input wire logic [10:0]         rom_addr,  // Fetch address.
	input wire pseq_pkg::pseq_ctx_s ctx,       // Accumulator and flags.
	input wire logic [7:0]          table_lo,  // Table low address.
	input wire logic [7:0]          table_hi,      // Table high address.
	input wire logic [7:0]          table_data_hi, // High byte of last table read.
	input wire logic [15:0]         rom_rdata,     // Program word at rom_addr.
	input wire logic                table_done     // Table done pulse.
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	reset_pc_a: assert property (disable iff (1'b0) srst |=> pc == 11'h000 && rom_addr == 11'h000)
		else $error("pc not cleared by reset");
	step_pc_a: assert property (cmd.op == pseq_pkg::PSEQ_OP_STEP |=> pc == $past(pc) + 11'h001)
		else $error("pc did not advance");
	irq_vector_a: assert property (cmd.op == pseq_pkg::PSEQ_OP_IRQ |=> pc == 11'h008)
		else $error("interrupt did not reach vector");
	add_carry_a: assert property (cmd.op == pseq_pkg::PSEQ_OP_ADDPCL |=>
		pc == $past(pc) + {3'h0, $past(ctx.accumulator)}) else $error("computed jump wrong");
	sub_borrow_a: assert property (cmd.op == pseq_pkg::PSEQ_OP_SUBPCL |=>
		pc == {$past(pc[10:8]), $past(pc[7:0]) - $past(ctx.accumulator)}) else $error("sub wrong");
	table_addr_a: assert property (cmd.op == pseq_pkg::PSEQ_OP_TABLE |=>
		rom_addr == {$past(table_hi[2:0]), $past(table_lo)}) else $error("table address wrong");
	cause_hold_a: assert property (!$past(srst) |=> $stable(ctx.program_flag_register[3:2]))
		else $error("cause flags changed");
	done_pulse_a: assert property (table_done |-> $past(cmd.op, 2) == pseq_pkg::PSEQ_OP_TABLE)
		else $error("table done without a table read");
	table_fetch_a: assert property (cmd.op == pseq_pkg::PSEQ_OP_TABLE |=> ##1 table_done)
		else $error("table read never finished");
	table_data_a: assert property (table_done |-> table_data_hi == $past(rom_rdata[15:8]))
		else $error("table high byte wrong");
	fetch_addr_a: assert property (cmd.op != pseq_pkg::PSEQ_OP_TABLE |=> rom_addr == pc)
		else $error("fetch address off the counter");
endmodule
bind pseq_top pseq_checker u_chk (.core_clk(core_clk), .srst(srst), .cmd(cmd), .pc(pc),
	.rom_addr(rom_addr), .ctx(ctx), .table_lo(table_lo), .table_hi(table_hi),
	.table_data_hi(table_data_hi), .rom_rdata(rom_rdata), .table_done(table_done));

// ### bench/pseq_top_bench.sv
// Self-checking bench for the program sequencer.
`timescale 1ns/100ps
module pseq_top_bench;
	typedef struct {pseq_pkg::pseq_op_e op; logic [10:0] t; logic [7:0] a; logic [10:0] e;} pseq_row_s;
	logic core_clk = 0, srst = 1, acc_wr = 0, flag_wr = 0, tlo_wr = 0, thi_wr = 0, table_done;
	pseq_pkg::pseq_cause_e rst_cause = pseq_pkg::PSEQ_RST_POWER;
	pseq_pkg::pseq_cmd_s   cmd = '0;
	pseq_pkg::pseq_ctx_s   ctx;
	logic [7:0]  acc_wdata = 0, flag_wdata = 0, taddr_wdata = 0, table_lo, table_hi, table_data_hi;
	logic [10:0] pc, rom_addr;
	logic [7:0]  pc_high_byte, pc_low_byte;
	logic [15:0] rom_rdata;
	int          mismatches = 0, samples_checked = 0, dones = 0;
	pseq_row_s   rows[9] = '{'{pseq_pkg::PSEQ_OP_JUMP, 11'h0FD, 8'h00, 11'h0FD},
		'{pseq_pkg::PSEQ_OP_ADDPCL, 0, 8'h03, 11'h100}, '{pseq_pkg::PSEQ_OP_SUBPCL, 0, 8'h01, 11'h1FF},
		'{pseq_pkg::PSEQ_OP_IRQ, 0, 0, 11'h008}, '{pseq_pkg::PSEQ_OP_STEP, 0, 0, 11'h009},
		'{pseq_pkg::PSEQ_OP_RET, 0, 0, 11'h1FF}, '{pseq_pkg::PSEQ_OP_CALL, 11'h7FF, 0, 11'h7FF},
		'{pseq_pkg::PSEQ_OP_STEP, 0, 0, 11'h000}, '{pseq_pkg::PSEQ_OP_RET, 0, 0, 11'h200}};
	pseq_pkg::pseq_cause_e cz[3] = '{pseq_pkg::PSEQ_RST_POWER, pseq_pkg::PSEQ_RST_WDOG, pseq_pkg::PSEQ_RST_EXT};
	logic [1:0]  cx[3] = '{2'b01, 2'b00, 2'b11};
	// Program memory answers in the same cycle with a word that encodes its own address.
	assign rom_rdata = {5'h15, rom_addr};
	always #25 core_clk = ~core_clk;
	always @(negedge core_clk) if (table_done === 1'b1) dones++;
	pseq_top dut (.core_clk(core_clk), .srst(srst), .rst_cause(rst_cause), .cmd(cmd),
		.acc_wr(acc_wr), .acc_wdata(acc_wdata), .flag_wr(flag_wr), .flag_wdata(flag_wdata),
		.tlo_wr(tlo_wr), .thi_wr(thi_wr), .taddr_wdata(taddr_wdata), .rom_rdata(rom_rdata),
		.pc(pc), .rom_addr(rom_addr), .pc_high_byte(pc_high_byte),
		.pc_low_byte(pc_low_byte), .ctx(ctx),
		.table_lo(table_lo), .table_hi(table_hi), .table_data_hi(table_data_hi),
		.table_done(table_done));
	task end_sim;
		if (mismatches == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One operation per call; the mid-cycle return keeps every drive on a fresh edge.
	task cyc(input pseq_pkg::pseq_op_e o, input logic [10:0] t, input logic [3:0] w, input logic [7:0] d);
		@(posedge core_clk);
		cmd <= '{o, t};
		{thi_wr, tlo_wr, flag_wr, acc_wr} <= w;
		acc_wdata <= d;
		flag_wdata <= d;
		taddr_wdata <= d;
		@(negedge core_clk);
	endtask
	task rst(input pseq_pkg::pseq_cause_e c, input int n);
		@(posedge core_clk);
		srst <= 1;
		rst_cause <= c;
		repeat (n) @(posedge core_clk);
		srst <= 0;
		@(posedge core_clk);
		@(negedge core_clk);
	endtask
	initial
	begin
		rst(pseq_pkg::PSEQ_RST_POWER, 12);
		foreach (rows[i])
		begin
			cyc(pseq_pkg::PSEQ_OP_NONE, 0, 4'h1, rows[i].a);
			cyc(rows[i].op, rows[i].t, 4'h0, 0);
			cyc(pseq_pkg::PSEQ_OP_NONE, 0, 4'h0, 0);
			chk(pc, rows[i].e);
			chk({pc_high_byte, pc_low_byte}, {5'h00, rows[i].e});
			chk({5'h00, rom_addr}, {5'h00, rows[i].e});
		end
		cyc(pseq_pkg::PSEQ_OP_NONE, 0, 4'h3, 8'hF3);
		cyc(pseq_pkg::PSEQ_OP_SAVE, 0, 4'h0, 0);
		cyc(pseq_pkg::PSEQ_OP_NONE, 0, 4'h3, 8'h11);
		cyc(pseq_pkg::PSEQ_OP_SAVE, 0, 4'h0, 0);
		cyc(pseq_pkg::PSEQ_OP_NONE, 0, 4'h3, 8'hA0);
		cyc(pseq_pkg::PSEQ_OP_RESTORE, 0, 4'h0, 0);
		cyc(pseq_pkg::PSEQ_OP_NONE, 0, 4'h0, 0);
		chk(ctx, 16'h1115);
		cyc(pseq_pkg::PSEQ_OP_NONE, 0, 4'hC, 8'hFF);
		cyc(pseq_pkg::PSEQ_OP_TABLE, 0, 4'h0, 0);
		repeat (2) cyc(pseq_pkg::PSEQ_OP_NONE, 0, 4'h0, 0);
		chk({table_data_hi, ctx.accumulator}, 16'hAFFF);
		cyc(pseq_pkg::PSEQ_OP_INC_TLO, 0, 4'h0, 0);
		cyc(pseq_pkg::PSEQ_OP_TABLE, 0, 4'h0, 0);
		repeat (3) cyc(pseq_pkg::PSEQ_OP_NONE, 0, 4'h0, 0);
		chk({table_hi, table_lo}, 16'hFF00);
		chk({table_data_hi, ctx.accumulator}, 16'hAF00);
		chk({8'h00, 8'(dones)}, 16'h0002);
		foreach (cz[i])
		begin
			cyc(pseq_pkg::PSEQ_OP_STEP, 11'h000, 4'h1, 8'h5A);
			cyc(pseq_pkg::PSEQ_OP_NONE, 11'h000, 4'h0, 8'h00);
			rst(cz[i], 2);
			chk({5'h0, pc}, 16'h0000);
			chk({14'h0, ctx.program_flag_register[3:2]}, {14'h0, cx[i]});
			cyc(pseq_pkg::PSEQ_OP_RESTORE, 11'h000, 4'h0, 8'h00);
			cyc(pseq_pkg::PSEQ_OP_NONE, 11'h000, 4'h0, 8'h00);
			chk(ctx, {8'h00, 4'h0, cx[i], 2'b00});
		end
		end_sim();
	end
	// About 80 cycles are needed; more than five times that marks a hang.
	initial
	begin
		#(50 * 450);
		mismatches++;
		end_sim();
	end
endmodule
